// File: pkg/csd_defs.svh
// chip select decoder constants: register indices, field positions,
// reset values and widths; included by the package and the design files
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// register indices, byte address is four times the index
`define CSD_IDX_UPPER      8'hA0
`define CSD_IDX_LOWER      8'hA2
`define CSD_IDX_PERIPH     8'hA4
`define CSD_IDX_MID        8'hA6
`define CSD_IDX_AUX        8'hA8
`define CSD_IDX_SYSCFG     8'hF0
`define CSD_IDX_STATUS     8'hF2

// reset values
`define CSD_UPPER_RST      16'hF03B
`define CSD_REG_RST        16'h0000

// fields common to all select registers
`define CSD_RDY_BIT        2
`define CSD_WS_LSB         0
// upper and lower: address bits 19:12 in bits 15:8
`define CSD_EDGE_LSB       8
// midrange base: address bits 19:13 in bits 15:9
`define CSD_MID_BASE_LSB   9
// peripheral base: address bits 19:10 in bits 15:6
`define CSD_PER_BASE_LSB   6
// peripheral extra wait bits 4:3 extend the count to 0..15
`define CSD_PER_WSHI_LSB   3
// auxiliary register fields
`define CSD_AUX_SIZE_LSB   8
`define CSD_AUX_SIZE_MAX   3'd6
`define CSD_AUX_MEMSP_BIT  6
`define CSD_AUX_EXP_BIT    7
// own system configuration register
`define CSD_SYS_MCS0_BIT   0

// decode shapes
`define CSD_PER_BLOCKS     7
`define CSD_MID_QSHIFT     5'd11

`endif

// File: pkg/csd_pkg.sv
// chip select decoder types: state enum and the state structs
// of the three modules; widths follow the constants header
`include "csd_defs.svh"

package csd_pkg;

    // gray along idle, wait, ready, done
    typedef enum logic [1:0] {
        CSD_IDLE  = 2'b00,
        CSD_WAIT  = 2'b01,
        CSD_READY = 2'b11,
        CSD_DONE  = 2'b10
    } csd_wg_state_e;

    typedef struct packed {
        csd_wg_state_e st;
        logic [3:0]    cnt;
    } csd_wg_s;

    typedef struct packed {
        logic        pend;
        logic        wr;
        logic [7:0]  idx;
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } csd_bus_s;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] periph;
        logic [15:0] mid;
        logic [15:0] aux;
        logic [15:0] syscfg;
        logic        lower_w;
        logic        per_w;
        logic        mid_w;
        logic        aux_w;
        logic        busy;
        logic        done;
        logic        last_dma;
        logic        ucs_n;
        logic        lcs_n;
        logic [3:0]  mcs_n;
        logic [3:0]  pcs_lo_n;
        logic [1:0]  pcs_hi_pin;
    } csd_core_s;

endpackage

// File: core/csd_wait_gen.sv
// wait-state and ready sequencer for one local bus cycle
// assumes start only while idle; ext_ready synchronous to clock
`timescale 1ns/1ps
`default_nettype none

module csd_wait_gen #(
    parameter int WS_W = 4
) (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    // cycle request
    input  wire logic            start,
    input  wire logic [WS_W-1:0] waits,
    input  wire logic            need_rdy,
    input  wire logic            ext_ready,
    // status
    output logic                 busy,
    output logic                 waiting,
    output logic                 done
);
    import csd_pkg::*;

    csd_wg_s s_r;
    csd_wg_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            CSD_IDLE: begin
                if (start) begin
                    s_nxt.st  = CSD_WAIT;
                    s_nxt.cnt = 4'(waits);
                end
            end
            CSD_WAIT: begin
                // programmed waits always run out before ready counts
                if (s_r.cnt != 4'h0) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else if (!need_rdy || ext_ready) begin
                    s_nxt.st = CSD_DONE;
                end else begin
                    s_nxt.st = CSD_READY;
                end
            end
            CSD_READY: begin
                if (ext_ready) begin
                    s_nxt.st = CSD_DONE;
                end
            end
            CSD_DONE: begin
                s_nxt.st = CSD_IDLE;
            end
            default: begin
                s_nxt.st = CSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: CSD_IDLE, cnt: 4'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy    = (s_r.st != CSD_IDLE);
    assign waiting = (s_r.st == CSD_READY);
    assign done    = (s_r.st == CSD_DONE);

endmodule

`default_nettype wire

// File: core/csd_ahb_if.sv
// ahb-lite slave front end: one wait state per transfer
// assumes single word transfers; response always okay
`timescale 1ns/1ps
`default_nettype none

module csd_ahb_if (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // register side
    output logic [7:0]       reg_idx,
    output logic             reg_wr,
    input  wire logic [15:0] rd_data
);
    import csd_pkg::*;

    csd_bus_s s_r;
    csd_bus_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.pend) begin
            s_nxt.pend      = 1'b0;
            s_nxt.hreadyout = 1'b1;
            s_nxt.hrdata    = s_r.wr ? 32'h0000_0000 : {16'h0000, rd_data};
        end else if (hsel && hready && htrans[1]) begin
            s_nxt.pend      = 1'b1;
            s_nxt.wr        = hwrite;
            s_nxt.idx       = haddr[9:2];
            s_nxt.hreadyout = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{pend: 1'b0, wr: 1'b0, idx: 8'h00, hreadyout: 1'b1,
                     hresp: 1'b0, hrdata: 32'h0000_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = s_r.hreadyout;
    assign hresp     = s_r.hresp;
    assign hrdata    = s_r.hrdata;
    assign reg_idx   = s_r.idx;
    assign reg_wr    = s_r.pend && s_r.wr;

endmodule

`default_nettype wire

// File: core/csd_top.sv
// chip select decoder: registers, address decode and select outputs
// assumes cyc_* from the cpu or dma bus unit, synchronous to clock
// What this block does
// - every cpu or dma cycle in a programmed region asserts its select, save peripheral block four and, in address mode, blocks five and six.
// - latched address bits A1 and A2 can replace the two top pins.
// - six memory selects cover upper, lower and midrange regions.
// - peripheral selects each decode 256 bytes above one base.
// - six 16-bit writable registers hold the configuration.
// - index A0h sets up the upper and A2h the lower region.
// - the four midrange selects use the A6h and A8h registers.
// - peripheral selects use the base and the shared aux register.
// - peripheral select four decodes but has no output pin.
// - a system configuration bit changes midrange select zero.
// - after reset the upper select covers the top 64K, 3 waits, ready.
// - other selects stay off until their registers are written.
// - a ready bit of 1 ignores external ready, 0 requires it.
// - waits go to 15 for peripheral 0..3 and to 3 for the rest.
`timescale 1ns/1ps
`default_nettype none

`include "csd_defs.svh"

module csd_top #(
    parameter int ADDR_W = 20
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // ahb-lite register bus
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // local bus cycle
    input  wire logic              cyc_start,
    input  wire logic [ADDR_W-1:0] cyc_addr,
    input  wire logic              cyc_io,
    input  wire logic              cyc_dma,
    input  wire logic              ext_ready,
    output logic                   cyc_busy,
    output logic                   cyc_done,
    // chip select pins
    output logic                   upper_region_select_n,
    output logic                   lower_region_select_n,
    output logic [3:0]             midrange_region_selects_n,
    output logic [3:0]             peripheral_block_selects_low_n,
    output logic [1:0]             peripheral_block_selects_high_n
);
    import csd_pkg::*;

    csd_core_s s_r;
    csd_core_s s_nxt;

    logic [7:0]        reg_idx;
    logic              reg_wr;
    logic [15:0]       rd_data;
    logic              wg_busy;
    logic              wg_wait;
    logic              wg_done;
    logic              start_ok;
    logic [3:0]        sel_ws;
    logic              sel_need;
    logic              mem_cyc;
    logic              mid_en;
    logic              per_en;
    logic              hit_up;
    logic              hit_lo;
    logic              hit_mid;
    logic [3:0]        mh;
    logic [6:0]        ph;
    logic [6:0]        ph_eff;
    logic [2:0]        msize;
    logic [ADDR_W-1:0] mid_base;
    logic [ADDR_W-1:0] mid_off;
    logic [ADDR_W-1:0] mid_sh;
    logic [ADDR_W:0]   mid_tot;
    logic [ADDR_W-1:0] per_base;
    logic [ADDR_W-1:0] per_off;
    logic              space_ok;

    // ready-required flag and 2-bit wait count of one select register
    function automatic logic [4:0] f_rdy_ws(input logic [15:0] r);
        f_rdy_ws = {!r[`CSD_RDY_BIT], 2'b00, r[`CSD_WS_LSB +: 2]};
    endfunction

    csd_ahb_if u_bus (
        .clock     (clock),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .reg_idx   (reg_idx),
        .reg_wr    (reg_wr),
        .rd_data   (rd_data)
    );

    csd_wait_gen #(.WS_W(4)) u_wait (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (start_ok),
        .waits     (sel_ws),
        .need_rdy  (sel_need),
        .ext_ready (ext_ready),
        .busy      (wg_busy),
        .waiting   (wg_wait),
        .done      (wg_done)
    );

    assign mid_en   = s_r.mid_w && s_r.aux_w;
    assign per_en   = s_r.per_w && s_r.aux_w;
    assign mem_cyc  = !cyc_io;
    assign start_ok = cyc_start && !s_r.busy && !wg_busy;

    assign per_base = {s_r.periph[15:`CSD_PER_BASE_LSB], 10'h000};
    assign per_off  = cyc_addr - per_base;
    assign space_ok = s_r.aux[`CSD_AUX_MEMSP_BIT] ? mem_cyc : cyc_io;

    // one 256-byte block per peripheral select
    generate
        for (genvar g = 0; g < `CSD_PER_BLOCKS; g++) begin : g_blk
            assign ph[g] = per_en && space_ok && (cyc_addr >= per_base)
                        && (per_off[ADDR_W-1:8] == (ADDR_W-8)'(g));
        end
    endgenerate

    // top two pins lose their selects in address mode
    assign ph_eff = {ph[6:5] & {2{s_r.aux[`CSD_AUX_EXP_BIT]}}, ph[4:0]};

    // upper, lower and midrange memory ranges
    always_comb begin
        hit_up = mem_cyc
              && (cyc_addr >= {s_r.upper[15:`CSD_EDGE_LSB], 12'h000});
        hit_lo = s_r.lower_w && mem_cyc
              && (cyc_addr <= {s_r.lower[15:`CSD_EDGE_LSB], 12'hFFF});
        msize  = s_r.aux[`CSD_AUX_SIZE_LSB +: 3];
        if (msize > `CSD_AUX_SIZE_MAX) begin
            msize = `CSD_AUX_SIZE_MAX;
        end
        // base from midrange register, size from aux register
        mid_base = {s_r.mid[15:`CSD_MID_BASE_LSB], 13'h0000};
        mid_off  = cyc_addr - mid_base;
        mid_tot  = (ADDR_W+1)'(21'h002000 << msize);
        mid_sh   = mid_off >> (`CSD_MID_QSHIFT + 5'(msize));
        hit_mid  = mid_en && mem_cyc && (cyc_addr >= mid_base)
                && ({1'b0, mid_off} < mid_tot);
        mh = 4'h0;
        if (hit_mid) begin
            // midrange zero may take the whole range
            if (s_r.syscfg[`CSD_SYS_MCS0_BIT]) begin
                mh = 4'h1;
            end else begin
                mh = 4'h1 << mid_sh[1:0];
            end
        end
    end

    // ready and wait count of the hit region
    always_comb begin
        {sel_need, sel_ws} = 5'h00;
        if (hit_up) begin
            {sel_need, sel_ws} = f_rdy_ws(s_r.upper);
        end else if (hit_lo) begin
            {sel_need, sel_ws} = f_rdy_ws(s_r.lower);
        end else if (hit_mid) begin
            {sel_need, sel_ws} = f_rdy_ws(s_r.mid);
        end else if (|ph_eff[3:0]) begin
            sel_need = !s_r.periph[`CSD_RDY_BIT];
            sel_ws   = {s_r.periph[`CSD_PER_WSHI_LSB +: 2],
                        s_r.periph[`CSD_WS_LSB +: 2]};
        end else if (|ph_eff[6:4]) begin
            // block four keeps its wait logic without a pin
            {sel_need, sel_ws} = f_rdy_ws(s_r.aux);
        end
    end

    // register read mux
    always_comb begin
        case (reg_idx)
            `CSD_IDX_UPPER:  rd_data = s_r.upper;
            `CSD_IDX_LOWER:  rd_data = s_r.lower;
            `CSD_IDX_PERIPH: rd_data = s_r.periph;
            `CSD_IDX_MID:    rd_data = s_r.mid;
            `CSD_IDX_AUX:    rd_data = s_r.aux;
            `CSD_IDX_SYSCFG: rd_data = s_r.syscfg;
            `CSD_IDX_STATUS: rd_data = {7'h00, s_r.last_dma, wg_wait,
                                        s_r.busy, s_r.aux_w, s_r.mid_w,
                                        s_r.per_w, s_r.lower_w, mid_en,
                                        per_en};
            default:         rd_data = 16'h0000;
        endcase
    end

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = wg_done;
        // cpu and dma cycles decode alike
        if (start_ok) begin
            s_nxt.busy     = 1'b1;
            s_nxt.last_dma = cyc_dma;
            // selects latched active low for the cycle
            s_nxt.ucs_n    = !hit_up;
            s_nxt.lcs_n    = !hit_lo;
            s_nxt.mcs_n    = ~mh;
            s_nxt.pcs_lo_n = ~ph_eff[3:0];
            // latched A2 and A1 on the top pins in address mode, selects of blocks six and five in select mode
            s_nxt.pcs_hi_pin = s_r.aux[`CSD_AUX_EXP_BIT] ? ~ph_eff[6:5]
                                                         : cyc_addr[2:1];
        end else if (wg_done) begin
            s_nxt.busy     = 1'b0;
            s_nxt.ucs_n    = 1'b1;
            s_nxt.lcs_n    = 1'b1;
            s_nxt.mcs_n    = 4'hF;
            s_nxt.pcs_lo_n = 4'hF;
            if (s_r.aux[`CSD_AUX_EXP_BIT]) begin
                s_nxt.pcs_hi_pin = 2'b11;
            end
        end else if (!s_r.busy && s_r.aux[`CSD_AUX_EXP_BIT]) begin
            // idle select pins stay released once switched to select mode
            s_nxt.pcs_hi_pin = 2'b11;
        end
        // five select registers plus own config
        if (reg_wr) begin
            case (reg_idx)
                `CSD_IDX_UPPER: s_nxt.upper = hwdata[15:0];
                `CSD_IDX_LOWER: begin
                    s_nxt.lower   = hwdata[15:0];
                    s_nxt.lower_w = 1'b1;
                end
                `CSD_IDX_PERIPH: begin
                    s_nxt.periph = hwdata[15:0];
                    s_nxt.per_w  = 1'b1;
                end
                `CSD_IDX_MID: begin
                    s_nxt.mid   = hwdata[15:0];
                    s_nxt.mid_w = 1'b1;
                end
                `CSD_IDX_AUX: begin
                    s_nxt.aux   = hwdata[15:0];
                    s_nxt.aux_w = 1'b1;
                end
                `CSD_IDX_SYSCFG: s_nxt.syscfg = hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // upper register comes out of reset active
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{upper: `CSD_UPPER_RST, lower: `CSD_REG_RST,
                     periph: `CSD_REG_RST, mid: `CSD_REG_RST,
                     aux: `CSD_REG_RST, syscfg: `CSD_REG_RST,
                     lower_w: 1'b0, per_w: 1'b0, mid_w: 1'b0, aux_w: 1'b0,
                     busy: 1'b0, done: 1'b0, last_dma: 1'b0,
                     ucs_n: 1'b1, lcs_n: 1'b1, mcs_n: 4'hF, pcs_lo_n: 4'hF,
                     pcs_hi_pin: 2'b00};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cyc_busy                        = s_r.busy;
    assign cyc_done                        = s_r.done;
    assign upper_region_select_n           = s_r.ucs_n;
    assign lower_region_select_n           = s_r.lcs_n;
    assign midrange_region_selects_n       = s_r.mcs_n;
    assign peripheral_block_selects_low_n  = s_r.pcs_lo_n;
    assign peripheral_block_selects_high_n = s_r.pcs_hi_pin;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic       sel_need_q;
    logic [3:0] sel_ws_q;

    sequence s_three_wait_gap;
        !wg_done [*4] ##1 wg_done;
    endsequence

    sequence s_released;
        s_r.ucs_n && s_r.lcs_n && (s_r.mcs_n == 4'hF)
            && (s_r.pcs_lo_n == 4'hF);
    endsequence

    property p_upper_reset_hit;
        start_ok && mem_cyc && (s_r.upper == `CSD_UPPER_RST)
            && (cyc_addr[19:16] == 4'hF)
            |=> !upper_region_select_n && sel_need_q && (sel_ws_q == 4'h3);
    endproperty
    a_upper_reset_hit: assert property (p_upper_reset_hit)
        else $error("upper select not active in top 64K after reset");

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_need_q <= 1'b0;
            sel_ws_q   <= 4'h0;
        end else if (start_ok) begin
            sel_need_q <= sel_need;
            sel_ws_q   <= sel_ws;
        end
    end

    property p_lower_gate;
        !s_r.lower_w |-> lower_region_select_n;
    endproperty
    a_lower_gate: assert property (p_lower_gate)
        else $error("lower select asserted before its register write");

    property p_mid_per_gate;
        !(s_r.mid_w && s_r.aux_w) && !(s_r.per_w && s_r.aux_w)
            |-> (midrange_region_selects_n == 4'hF)
             && (peripheral_block_selects_low_n == 4'hF);
    endproperty
    a_mid_per_gate: assert property (p_mid_per_gate)
        else $error("midrange or peripheral select before both writes");

    property p_three_waits;
        start_ok && !sel_need && (sel_ws == 4'h3) |=> s_three_wait_gap;
    endproperty
    a_three_waits: assert property (p_three_waits)
        else $error("three wait states not counted exactly");

    property p_ready_hold;
        wg_wait && !ext_ready |=> !wg_done;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("cycle ended without external ready");

    property p_hold_cycle;
        s_r.busy && !wg_done |=> $stable(midrange_region_selects_n)
            && $stable(upper_region_select_n) && $stable(lower_region_select_n);
    endproperty
    a_hold_cycle: assert property (p_hold_cycle)
        else $error("select changed inside a bus cycle");

    property p_release;
        wg_done |=> s_released and cyc_done;
    endproperty
    a_release: assert property (p_release)
        else $error("selects not released at cycle end");

    property p_addr_latch;
        start_ok && !s_r.aux[`CSD_AUX_EXP_BIT]
            |=> peripheral_block_selects_high_n == $past(cyc_addr[2:1]);
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("latched address bits wrong on top pins");

    property p_io_no_mem;
        start_ok && cyc_io |=> upper_region_select_n && lower_region_select_n
            && (midrange_region_selects_n == 4'hF);
    endproperty
    a_io_no_mem: assert property (p_io_no_mem)
        else $error("memory select asserted on an i/o cycle");

    property p_lower_write;
        reg_wr && (reg_idx == `CSD_IDX_LOWER)
            |=> (s_r.lower == $past(hwdata[15:0])) && s_r.lower_w;
    endproperty
    a_lower_write: assert property (p_lower_write)
        else $error("lower region register write lost");

endmodule

`default_nettype wire

// File: sim/csd_bus_partner.sv
// far side of the local bus: answers ready to the asserted selects
// assumes selects active low; slow holds ready low for six cycles
`timescale 1ns/1ps
`default_nettype none

module csd_bus_partner (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // behaviour and pins
    input  wire logic       slow,
    input  wire logic [9:0] sel_n,
    output logic            ext_ready
);
    logic [3:0] cnt;
    logic       tgl;
    logic       hit;
    assign hit = ~&sel_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            tgl <= 1'b0;
        end else begin
            tgl <= ~tgl;
            cnt <= (hit && cnt != 4'hF) ? cnt + 4'h1 : (hit ? cnt : 4'h0);
        end
    end
    // memory or i/o alike
    // unselected: ready line toggles, no held value
    assign ext_ready = hit ? (!slow || cnt >= 4'h6) : tgl;
endmodule

`default_nettype wire

// File: sim/tb_top.sv
// bench for the chip select decoder: register model and cycle checks
// assumes one-wait ahb slave and a prompt or stalling partner
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, g, e) begin checked++; if ((g) !== (e)) begin errors++; \
$display("ERROR %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0, phi_n;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, cyc_start = 0, cyc_io = 0, cyc_dma = 0;
    logic        ext_ready, cyc_busy, cyc_done, slow = 0, ucs_n, lcs_n;
    logic [19:0] cyc_addr = '0;
    logic [3:0]  mcs_n, plo_n;
    logic [11:0] pins;
    logic [15:0] rg [5] = '{16'hF03B, 0, 0, 0, 0};
    bit          wn [5];
    bit          mz, dm;
    int          errors = 0, checked = 0;
    assign pins = {ucs_n, lcs_n, mcs_n, plo_n, phi_n};
    always #2 clock = ~clock;

    csd_top i_dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cyc_start,
        .cyc_addr, .cyc_io, .cyc_dma, .ext_ready, .cyc_busy, .cyc_done,
        .upper_region_select_n(ucs_n), .lower_region_select_n(lcs_n),
        .midrange_region_selects_n(mcs_n),
        .peripheral_block_selects_low_n(plo_n),
        .peripheral_block_selects_high_n(phi_n));
    csd_bus_partner i_far (.clock, .rst_n, .slow, .sel_n(pins[11:2]),
        .ext_ready);

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic ahb(input bit wr, input int idx, input int wd);
        @(posedge clock);
        hsel <= 1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= idx * 4;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", hresp, 1'b0)
        if (wr && idx >= 'hA0 && idx <= 'hA8 && idx % 2 == 0) begin
            rg[(idx - 'hA0) / 2] = wd[15:0];
            wn[(idx - 'hA0) / 2] = 1;
        end
        if (wr && idx == 'hF0) mz = wd[0];
    endtask

    task automatic regs();
        for (int i = 'hA0; i <= 'hA8; i += 2) begin
            ahb(0, i, 0);
            `CHK("register", rd, {16'h0, rg[(i - 'hA0) / 2]})
        end
    endtask

    function automatic void model(input int a, input bit io,
                                  output logic [11:0] s, output int n,
                                  output bit ig);
        int b, m, q, k;
        b = rg[2][15:6] << 10;
        m = rg[3][15:9] << 13;
        q = 2048 << (rg[4][10:8] > 6 ? 6 : rg[4][10:8]);
        k = (a - b) >> 8;
        s = {10'h3FF, rg[4][7] ? 2'b11 : a[2:1]};
        n = 0;
        ig = 1;
        if (wn[2] && wn[4] && rg[4][6] != io && a >= b && k < 7) begin
            if (k < 4) begin
                s[2 + k] = 0;
                n = {rg[2][4:3], rg[2][1:0]};
                ig = rg[2][2];
            end else if (k == 4 || rg[4][7]) begin
                n = rg[4][1:0];
                ig = rg[4][2];
                if (k > 4) s[k - 5] = 0;
            end
        end
        if (wn[3] && wn[4] && !io && a >= m && a < m + 4 * q) begin
            s[6 + (mz ? 0 : (a - m) / q)] = 0;
            n = rg[3][1:0];
            ig = rg[3][2];
        end
        if (wn[1] && !io && a <= {rg[1][15:8], 12'hFFF}) begin
            s[10] = 0;
            n = rg[1][1:0];
            ig = rg[1][2];
        end
        if (!io && a >= {rg[0][15:8], 12'h000}) begin
            s[11] = 0;
            n = rg[0][1:0];
            ig = rg[0][2];
        end
    endfunction

    task automatic cyc(input int a, input bit io, input bit sl);
        logic [11:0] es;
        int          n, k;
        bit          ig;
        model(a, io, es, n, ig);
        @(posedge clock);
        slow <= sl;
        cyc_addr <= a[19:0];
        cyc_io <= io;
        dm = 1'($urandom);
        cyc_dma <= dm;
        cyc_start <= 1;
        @(posedge clock);
        cyc_start <= 0;
        k = 1;
        #1;
        while (cyc_done !== 1'b1 && k < 60) begin
            `CHK("selects", pins, es)
            `CHK("busy", cyc_busy, 1'b1)
            @(posedge clock);
            #1 k++;
        end
        `CHK("release", pins, {10'h3FF, rg[4][7] ? 2'b11 : a[2:1]})
        `CHK("idle", cyc_busy, 1'b0)
        `CHK("cycles", k, (sl && !ig && n < 6) ? 9 : n + 3)
    endtask

    initial begin
        void'($urandom(80502));
        repeat (4) @(posedge clock);
        rst_n <= 1;
        regs();
        ahb(1, 'h10, 'h1234);
        ahb(0, 'h10, 0);
        `CHK("unmapped", rd, 32'h0)
        cyc('hF0000 + $urandom_range('hFFFF), 0, 0);
        cyc('hF8000, 0, 1);
        cyc('h00100, 0, 0);
        ahb(1, 'hA2, 'hFFFF1F07);
        cyc('h01000 + $urandom_range('hEFFF), 0, 1);
        ahb(1, 'hA6, 'h4005);
        cyc('h40800, 0, 0);
        ahb(1, 'hA8, 'h00C4);
        for (int j = 0; j < 4; j++)
            cyc('h40000 + j * 'h800 + $urandom_range('h7FF), 0, 0);
        ahb(1, 'hF0, 1);
        cyc('h41000 + $urandom_range('h7FF), 0, 0);
        ahb(0, 'hF2, 0);
        `CHK("status", rd, {23'h0, dm, 8'h36})
        ahb(1, 'hA4, 'h301F);
        for (int j = 0; j < 7; j++)
            cyc('h30000 + j * 256 + $urandom_range(255), 0, 0);
        cyc('h30000, 1, 0);
        ahb(1, 'hA8, 'h0084);
        cyc('h30100, 1, 0);
        ahb(1, 'hA8, 'h0004);
        for (int j = 0; j < 4; j++)
            cyc('h30500 + $urandom_range(255), 1, 0);
        regs();
        end_sim();
    end

    initial begin
        #40000;
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
